// ---- clvd_pkg.sv ----
package clvd_pkg;
    // Register indices of the parameter objects
    localparam logic [7:0] REG_ENTRY_COUNT   = 8'h00;
    localparam logic [7:0] REG_VIN1_FUNC     = 8'h01;
    localparam logic [7:0] REG_FILTER_TIME   = 8'h0E;
    localparam logic [7:0] REG_DEVIATION     = 8'h11;
    localparam logic [7:0] REG_INT_FEEDBACK  = 8'h13;
    localparam logic [7:0] REG_EXT_FEEDBACK  = 8'h15;
    // Reset and fixed values
    localparam logic [7:0]  ENTRY_COUNT_VAL  = 8'h41;
    localparam logic [15:0] VIN1_FUNC_RST    = 16'h0000;
    localparam logic [15:0] FILTER_TIME_RST  = 16'h0000;
    localparam logic [31:0] COUNT_RST        = 32'h0000_0000;
    localparam logic [15:0] CLEAR_ALWAYS     = 16'h0000;
    localparam logic [15:0] CLEAR_MAX        = 16'h0064;
    localparam logic [31:0] THRESH_OFF       = 32'h0000_0000;
    localparam logic [15:0] REV_CNT_ZERO     = 16'h0000;
    localparam logic [15:0] REV_STEP         = 16'h0001;
    // Feedback source selection, input and function counts
    localparam logic [1:0]  SRC_INTERNAL     = 2'h0;
    localparam int          NUM_VIN          = 9;
    localparam int          NUM_FUNC         = 40;

    // Decoded virtual input functions
    typedef struct packed {
        logic fault_reset_input;
        logic gain_switch;
        logic zero_hold_input;
        logic reference_inhibit;
        logic positive_travel_limit;
        logic negative_travel_limit;
        logic positive_torque_cap;
        logic negative_torque_cap;
        logic forward_inch_input;
        logic reverse_inch_input;
        logic torque_sense_select;
        logic speed_sense_select;
        logic position_sense_select;
        logic origin_sensor_input;
        logic urgent_halt_input;
        logic deviation_zero_input;
        logic speed_cap_source_select;
        logic latch_trigger_1;
        logic latch_trigger_2;
    } clvd_func_t;

    // Parameter write strobe with address and data
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] data;
    } clvd_wr_t;
endpackage

// ---- clvd_func_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module clvd_func_decode (
    input  wire logic [15:0]        func_code,  // Function selector
    input  wire logic               level,      // Input logic level
    output clvd_pkg::clvd_func_t    funcs       // Decoded functions
);
    import clvd_pkg::*;

    // Map one function code onto the function vector
    always_comb begin
        funcs = '0;
        case (func_code)
            16'h0002: funcs.fault_reset_input       = level;
            16'h0003: funcs.gain_switch             = level;
            16'h000C: funcs.zero_hold_input         = level;
            16'h000D: funcs.reference_inhibit       = level;
            16'h000E: funcs.positive_travel_limit   = level;
            16'h000F: funcs.negative_travel_limit   = level;
            16'h0010: funcs.positive_torque_cap     = level;
            16'h0011: funcs.negative_torque_cap     = level;
            16'h0012: funcs.forward_inch_input      = level;
            16'h0013: funcs.reverse_inch_input      = level;
            16'h0019: funcs.torque_sense_select     = level;
            16'h001A: funcs.speed_sense_select      = level;
            16'h001B: funcs.position_sense_select   = level;
            16'h001F: funcs.origin_sensor_input     = level;
            16'h0022: funcs.urgent_halt_input       = level;
            16'h0023: funcs.deviation_zero_input    = level;
            16'h0024: funcs.speed_cap_source_select = level;
            16'h0026: funcs.latch_trigger_1         = level;
            16'h0027: funcs.latch_trigger_2         = level;
            default:  funcs = '0;
        endcase
    end
endmodule
`default_nettype wire

// ---- clvd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module clvd_top (
    input  wire logic                sys_clk,         // 50 MHz clock
    input  wire logic                resetn,          // Sync reset, low
    input  wire clvd_pkg::clvd_wr_t  param_wr,        // Parameter write
    input  wire logic [7:0]          param_rd_addr,   // Parameter read index
    output logic [31:0]              param_rd_data,   // Read data
    input  wire logic [15:0]         clear_setting,   // Revolutions per clear
    input  wire logic [31:0]         excess_threshold,// Excess threshold
    input  wire logic [1:0]          feedback_source, // 0 internal
    input  wire logic                drive_running,   // Running state
    input  wire logic                int_pulse_valid, // Internal pulse strobe
    input  wire logic signed [15:0]  int_pulse_delta, // Scaled internal step
    input  wire logic                ext_pulse_valid, // External pulse strobe
    input  wire logic signed [15:0]  ext_pulse_delta, // Scaled external step
    input  wire logic [31:0]         motor_resolution,// Pulses per rev
    input  wire logic [31:0]         ext_per_rev,     // Ext pulses per rev
    input  wire logic [8:0]          virtual_input,   // Normal input levels
    input  wire logic                forced_input_en, // Forced input active
    input  wire logic [8:0]          forced_input_value, // Forced levels
    input  wire logic [15:0]         other_vin_func [1:8], // Inputs 2..9
    output clvd_pkg::clvd_func_t     vin1_funcs,      // Input 1 functions
    output logic [15:0]              filter_time_applied, // 0 if internal
    output logic                     deviation_excess_fault, // Sticky
    output logic                     duplicate_assignment_fault // Level
);
    import clvd_pkg::*;

    logic [15:0]        vin1_func, next_vin1_func;
    logic [15:0]        filter_time, next_filter_time;
    logic signed [31:0] int_count, next_int_count;
    logic signed [31:0] ext_count, next_ext_count;
    logic signed [31:0] int_base, next_int_base;
    logic signed [31:0] ext_base, next_ext_base;
    logic signed [31:0] rev_acc, next_rev_acc;
    logic [15:0]        rev_count, next_rev_count;
    logic               fault, next_fault;
    logic [31:0]        rd_data, next_rd_data;
    logic signed [31:0] deviation;
    logic signed [63:0] conv_wide;
    logic signed [63:0] int_span;
    logic signed [63:0] divisor;
    logic [31:0]        dev_mag;
    logic               over, clear_now;
    logic [8:0]         vin_level;
    logic [15:0]        func_tab [0:NUM_VIN-1];
    logic               dup;

    // Deviation from counts relative to the last clear point
    always_comb begin
        // Internal travel since the last clear, sign extended
        int_span  = 64'(int_count - int_base);
        // A zero resolution would divide by zero, so one is used
        divisor   = (motor_resolution == 32'h0)
                    ? 64'sh1 : $signed({32'h0, motor_resolution});
        conv_wide = (int_span * $signed({32'h0, ext_per_rev})) / divisor;
        deviation = (ext_count - ext_base) - conv_wide[31:0];
        dev_mag   = deviation[31] ? 32'(-deviation) : deviation;
        over      = dev_mag > excess_threshold;
    end

    // Clear decision
    always_comb begin
        clear_now = 1'b0;
        if (clear_setting == CLEAR_ALWAYS) begin
            clear_now = 1'b1;
        end else if (excess_threshold == THRESH_OFF) begin
            clear_now = 1'b1;
        end else if (over) begin
            clear_now = 1'b1;
        end else if (clear_setting <= CLEAR_MAX
                     && rev_count >= clear_setting) begin
            clear_now = 1'b1;
        end
    end

    // Counters, revolution tracking and fault next values
    always_comb begin
        next_int_count = int_count;
        next_ext_count = ext_count;
        next_int_base  = int_base;
        next_ext_base  = ext_base;
        next_rev_acc   = rev_acc;
        next_rev_count = rev_count;
        next_fault     = fault;
        if (int_pulse_valid) begin
            next_int_count = int_count + 32'(int_pulse_delta);
        end
        if (ext_pulse_valid) begin
            next_ext_count = ext_count + 32'(ext_pulse_delta);
        end
        // Revolutions pause, not restart, outside the running state
        if (drive_running) begin
            if (int_pulse_valid) begin
                next_rev_acc = rev_acc + 32'(int_pulse_delta);
            end
            if (motor_resolution != 32'h0 && (next_rev_acc
                >= $signed(motor_resolution) || -next_rev_acc
                >= $signed(motor_resolution))) begin
                next_rev_acc   = 32'sh0;
                next_rev_count = rev_count + REV_STEP;
            end
        end
        // Rebase both counters so the deviation restarts at zero
        if (clear_now) begin
            next_int_base = next_int_count;
            next_ext_base = next_ext_count;
            if (clear_setting != CLEAR_ALWAYS && !over) begin
                next_rev_count = REV_CNT_ZERO;
                next_rev_acc   = 32'sh0;
            end
        end
        // Sticky excess fault, cleared only by reset
        if (over && clear_setting != CLEAR_ALWAYS
            && excess_threshold != THRESH_OFF
            && feedback_source != SRC_INTERNAL) begin
            next_fault = 1'b1;
        end
    end

    // Parameter writes and read mux
    always_comb begin
        next_vin1_func   = vin1_func;
        next_filter_time = filter_time;
        if (param_wr.wr && param_wr.addr == REG_VIN1_FUNC) begin
            next_vin1_func = param_wr.data;
        end
        if (param_wr.wr && param_wr.addr == REG_FILTER_TIME) begin
            next_filter_time = param_wr.data;
        end
        // Unmapped places read as zero
        case (param_rd_addr)
            REG_ENTRY_COUNT:  next_rd_data = {24'h0, ENTRY_COUNT_VAL};
            REG_VIN1_FUNC:    next_rd_data = {16'h0, vin1_func};
            REG_FILTER_TIME:  next_rd_data = {16'h0, filter_time};
            REG_DEVIATION:    next_rd_data = deviation;
            REG_INT_FEEDBACK: next_rd_data = int_count;
            REG_EXT_FEEDBACK: next_rd_data = ext_count;
            default:          next_rd_data = COUNT_RST;
        endcase
    end

    // State registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            vin1_func   <= VIN1_FUNC_RST;
            filter_time <= FILTER_TIME_RST;
            int_count   <= COUNT_RST;
            ext_count   <= COUNT_RST;
            int_base    <= COUNT_RST;
            ext_base    <= COUNT_RST;
            rev_acc     <= COUNT_RST;
            rev_count   <= REV_CNT_ZERO;
            fault       <= 1'b0;
            rd_data     <= COUNT_RST;
        end else begin
            vin1_func   <= next_vin1_func;
            filter_time <= next_filter_time;
            int_count   <= next_int_count;
            ext_count   <= next_ext_count;
            int_base    <= next_int_base;
            ext_base    <= next_ext_base;
            rev_acc     <= next_rev_acc;
            rev_count   <= next_rev_count;
            fault       <= next_fault;
            rd_data     <= next_rd_data;
        end
    end

    // Input levels with forced override
    assign vin_level = forced_input_en ? forced_input_value
                                       : virtual_input;

    // Function table of all nine inputs
    always_comb begin
        func_tab[0] = vin1_func;
        for (int k = 1; k < NUM_VIN; k++) begin
            func_tab[k] = other_vin_func[k];
        end
    end

    // Any nonzero function shared by two inputs
    always_comb begin
        dup = 1'b0;
        for (int a = 0; a < NUM_VIN; a++) begin
            for (int b = a + 1; b < NUM_VIN; b++) begin
                if (func_tab[a] != 16'h0000
                    && func_tab[a] == func_tab[b]) begin
                    dup = 1'b1;
                end
            end
        end
    end

    clvd_func_decode u_dec (
        .func_code (vin1_func),
        .level     (vin_level[0]),
        .funcs     (vin1_funcs)
    );

    // Output drive, filter applied only with external feedback
    assign param_rd_data              = rd_data;
    assign filter_time_applied        = (feedback_source != SRC_INTERNAL)
                                        ? filter_time : 16'h0000;
    assign deviation_excess_fault     = fault;
    assign duplicate_assignment_fault = dup;
endmodule
`default_nettype wire

// ---- clvd_enc_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module clvd_enc_model (
    input  wire logic               sys_clk, // Clock
    input  wire logic               go,      // Emit one step
    input  wire logic signed [15:0] step,    // Step size
    output logic                    valid,   // One-cycle strobe
    output logic signed [15:0]      delta    // Step, junk when idle
);
    // Idle data is inverted each cycle so a stale step never looks valid
    initial delta = 16'h5A5A;
    always @(posedge sys_clk) begin
        valid <= go;
        delta <= go ? step : ~delta;
    end
endmodule
`default_nettype wire

// ---- clvd_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module clvd_properties import clvd_pkg::*; (
    input wire logic               sys_clk,          // Clock
    input wire logic               resetn,           // Reset, low
    input wire clvd_pkg::clvd_wr_t param_wr,         // Write
    input wire logic [7:0]         param_rd_addr,    // Read index
    input wire logic [31:0]        param_rd_data,    // Read data
    input wire logic [31:0]        excess_threshold, // Threshold
    input wire logic [1:0]         feedback_source,  // Source
    input wire logic [8:0]         virtual_input,    // Levels
    input wire logic               forced_input_en,  // Forced on
    input wire logic [8:0]         forced_input_value,  // Forced
    input wire clvd_pkg::clvd_func_t vin1_funcs,     // Decode
    input wire logic [15:0]        filter_time_applied, // Filter
    input wire logic               deviation_excess_fault // Fault
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Excess fault behaviour
    fault_hold_a: assert property (
        deviation_excess_fault |=> deviation_excess_fault)
        else $error("fault fell");
    fault_source_a: assert property ($rose(deviation_excess_fault)
        |-> $past(feedback_source) != SRC_INTERNAL) else $error("src");
    fault_thresh_a: assert property ($rose(deviation_excess_fault)
        |-> $past(excess_threshold) != THRESH_OFF) else $error("thr");
    // Filter time constant
    filter_int_a: assert property (feedback_source == SRC_INTERNAL
        |-> filter_time_applied == 16'h0000) else $error("filter");
    filter_wr_a: assert property ((param_wr.wr &&
        param_wr.addr == REG_FILTER_TIME && feedback_source != 2'h0)
        ##1 feedback_source != 2'h0 |-> filter_time_applied ==
        $past(param_wr.data)) else $error("filter write");
    // Read path
    entry_read_a: assert property (param_rd_addr == REG_ENTRY_COUNT
        |=> param_rd_data == 32'h0000_0041) else $error("entry");
    unmapped_read_a: assert property (param_rd_addr == 8'h02
        |=> param_rd_data == 32'h0000_0000) else $error("unmapped");
    // Input 1 decode
    vin_level_a: assert property (vin1_funcs != '0 |->
        (forced_input_en ? forced_input_value[0] : virtual_input[0]))
        else $error("level");
    vin_onehot_a: assert property ($onehot0(vin1_funcs))
        else $error("decode");
    cover property ($rose(deviation_excess_fault));
    cover property (vin1_funcs.latch_trigger_2);
    cover property (forced_input_en && vin1_funcs != '0);
endmodule
bind clvd_top clvd_properties u_chk (.sys_clk, .resetn, .param_wr,
    .param_rd_addr, .param_rd_data, .excess_threshold, .feedback_source,
    .virtual_input, .forced_input_en, .forced_input_value, .vin1_funcs,
    .filter_time_applied, .deviation_excess_fault);
`default_nettype wire

// ---- clvd_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module clvd_top_tb;
    import clvd_pkg::*;
    logic         sys_clk = 0, resetn = 0, drive_running = 1;
    logic         forced_input_en = 0, ig = 0, eg = 0;
    logic         int_pulse_valid, ext_pulse_valid;
    logic         deviation_excess_fault, duplicate_assignment_fault;
    logic signed [15:0] ist = 0, est = 0, int_pulse_delta, ext_pulse_delta;
    logic [1:0]   feedback_source = 0;
    logic [7:0]   param_rd_addr = 0;
    logic [8:0]   virtual_input = 1, forced_input_value = 0;
    logic [15:0]  clear_setting = 16'h65, filter_time_applied;
    logic [15:0]  other_vin_func [1:8];
    logic [31:0]  excess_threshold = 32'h3E8, motor_resolution = 32'hA;
    logic [31:0]  ext_per_rev = 32'hF, param_rd_data;
    clvd_wr_t     param_wr = '0;
    clvd_func_t   vin1_funcs;
    int           errors = 0, samples_checked = 0;
    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;
    // Encoders, then the block
    clvd_enc_model int_enc (.sys_clk, .go(ig), .step(ist),
        .valid(int_pulse_valid), .delta(int_pulse_delta));
    clvd_enc_model ext_enc (.sys_clk, .go(eg), .step(est),
        .valid(ext_pulse_valid), .delta(ext_pulse_delta));
    clvd_top uut (.sys_clk, .resetn, .param_wr, .param_rd_addr,
        .param_rd_data, .clear_setting, .excess_threshold,
        .feedback_source, .drive_running, .int_pulse_valid,
        .int_pulse_delta, .ext_pulse_valid, .ext_pulse_delta,
        .motor_resolution, .ext_per_rev, .virtual_input,
        .forced_input_en, .forced_input_value, .other_vin_func,
        .vin1_funcs, .filter_time_applied, .deviation_excess_fault,
        .duplicate_assignment_fault);
    // Shared compare, bus cycles and steps
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge sys_clk) param_wr <= '{1'b1, a, d};
        @(posedge sys_clk) param_wr.wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge sys_clk) param_rd_addr <= a;
        repeat (2) @(posedge sys_clk);
        #1 chk("read data", e, param_rd_data);
    endtask
    task automatic step(logic signed [15:0] i, logic signed [15:0] e);
        @(posedge sys_clk) {ig, eg, ist, est} <= {i != 0, e != 0, i, e};
        @(posedge sys_clk) {ig, eg} <= 2'h0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic reset_dut;
        @(posedge sys_clk) resetn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
    endtask
    // Reset values, read-only and unmapped places
    task automatic t_regs;
        rd(REG_VIN1_FUNC, 32'h0);
        rd(REG_FILTER_TIME, 32'h0);
        rd(REG_INT_FEEDBACK, 32'h0);
        rd(REG_EXT_FEEDBACK, 32'h0);
        wr(REG_DEVIATION, 16'h1234);
        rd(REG_DEVIATION, 32'h0);
        rd(8'h02, 32'h0);
        rd(REG_ENTRY_COUNT, 32'h41);
    endtask
    // Full-range filter time, applied only with external feedback
    task automatic t_filter;
        feedback_source <= 2'h1;
        wr(REG_FILTER_TIME, 16'hFFFF);
        rd(REG_FILTER_TIME, 32'hFFFF);
        chk("filter", 32'hFFFF, {16'h0, filter_time_applied});
        @(posedge sys_clk) feedback_source <= 2'h0;
        @(posedge sys_clk) #1 chk("filter", 0, filter_time_applied);
    endtask
    // Accumulators, deviation, continuous clear
    task automatic t_accum;
        step(16'sh3, 16'sh7);
        rd(REG_INT_FEEDBACK, 32'h3);
        rd(REG_EXT_FEEDBACK, 32'h7);
        rd(REG_DEVIATION, 32'h3);
        step(-16'sh5, 16'sh0);
        rd(REG_INT_FEEDBACK, 32'hFFFF_FFFE);
        rd(REG_DEVIATION, 32'hA);
        clear_setting <= 16'h0;
        rd(REG_DEVIATION, 32'h0);
        step(16'sh2, -16'sh4);
        rd(REG_DEVIATION, 32'h0);
    endtask
    // Periodic clear every two revolutions, held while stopped
    task automatic t_rev;
        reset_dut;
        clear_setting <= 16'h2;
        step(16'shA, 16'shB);
        rd(REG_DEVIATION, 32'hFFFF_FFFC);
        drive_running <= 1'b0;
        step(16'shA, 16'shB);
        rd(REG_DEVIATION, 32'hFFFF_FFF8);
        drive_running <= 1'b1;
        step(16'shA, 16'sh0);
        rd(REG_DEVIATION, 32'h0);
        step(16'sh0, 16'sh3);
        rd(REG_DEVIATION, 32'h3);
    endtask
    // Every decoded code, forced levels, duplicate function
    task automatic t_vin;
        int c[19] = '{2, 3, 12, 13, 14, 15, 16, 17, 18, 19, 25, 26, 27,
                      31, 34, 35, 36, 38, 39};
        foreach (c[i]) begin
            wr(REG_VIN1_FUNC, 16'(c[i]));
            @(posedge sys_clk) #1;
            chk("decode", 1 << (18 - i), vin1_funcs);
        end
        wr(REG_VIN1_FUNC, 16'h1E);
        @(posedge sys_clk) #1 chk("decode", 0, vin1_funcs);
        wr(REG_VIN1_FUNC, 16'h2);
        {forced_input_en, virtual_input} <= {1'b1, 9'h1};
        @(posedge sys_clk) #1 chk("forced", 0, vin1_funcs);
        @(posedge sys_clk) forced_input_value <= 9'h001;
        other_vin_func[3] <= 16'h2;
        @(posedge sys_clk) #1 chk("forced", 1 << 18, vin1_funcs);
        chk("duplicate", 1, duplicate_assignment_fault);
        @(posedge sys_clk) other_vin_func[3] <= 16'h0;
        @(posedge sys_clk) #1;
        chk("duplicate", 0, duplicate_assignment_fault);
    endtask
    // Zero threshold, then excess with external feedback
    task automatic t_fault;
        reset_dut;
        {clear_setting, excess_threshold} <= {16'h5, 32'h0};
        feedback_source <= 2'h1;
        step(16'sh0, 16'sh32);
        rd(REG_DEVIATION, 32'h0);
        chk("fault", 0, deviation_excess_fault);
        excess_threshold <= 32'hA;
        step(16'sh0, 16'sh32);
        rd(REG_DEVIATION, 32'h0);
        chk("fault", 1, deviation_excess_fault);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog
    initial begin
        #400000;
        errors++;
        conclude;
    end
    // Main sequence
    initial begin
        foreach (other_vin_func[i]) other_vin_func[i] = 16'h0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        t_regs;
        t_filter;
        t_accum;
        t_rev;
        t_vin;
        t_fault;
        conclude;
    end
endmodule
`default_nettype wire
